// >>> verilog/bspc_pkg.sv
`default_nettype none
package bspc_pkg;
  // Command codes taken from the host after a transaction start.
  localparam logic [7:0] BSPC_CMD_READ_BUF = 8'h44;
  localparam logic [7:0] BSPC_CMD_READ_STATUS = 8'h55;
  localparam logic [7:0] BSPC_CMD_GPIO_WRITE = 8'h66;

  // Shared buffer geometry.
  localparam int BSPC_BUF_DEPTH = 8;
  localparam logic [3:0] BSPC_BUF_MAX_LEN = 4'h8;

  // Status byte field positions.
  localparam int BSPC_ST_PORT_A_WRITER = 0;
  localparam int BSPC_ST_PORT_B_WRITER = 1;
  localparam int BSPC_ST_FIRST_LINE = 2;
  localparam int BSPC_ST_SECOND_LINE_SUPPLY = 3;
  localparam int BSPC_ST_CHARGE_CMP = 4;
  localparam int BSPC_ST_GRANT = 5;
  localparam int BSPC_ST_TIMER_RESTART = 6;
  localparam int BSPC_ST_POWER_SOURCE = 7;

  // General pin output byte layout and its reset value (all pins released).
  localparam int BSPC_GPIO_A_BIT = 0;
  localparam int BSPC_GPIO_B_BIT = 1;
  localparam int BSPC_GPIO_C_BIT = 2;
  localparam logic [7:0] BSPC_GPIO_LATCH_RST = 8'h87;

  // Check word: reflected form of x16+x15+x2+1, seeded with zero.
  localparam logic [15:0] BSPC_CRC_POLY_REFL = 16'ha001;
  localparam logic [15:0] BSPC_CRC_SEED = 16'h0000;

  // Byte positions past the payload: check word low byte, then high byte.
  localparam logic [3:0] BSPC_CRC_BYTES = 4'h2;
endpackage : bspc_pkg
`default_nettype wire

// >>> verilog/bspc_byte_if.sv
`timescale 1ns/1ps
`default_nettype none
// Byte stream with valid and ready between the engine and its output buffer.
interface bspc_byte_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : bspc_byte_if
`default_nettype wire

// >>> verilog/bspc_skid_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module bspc_skid_fifo (
  input wire logic clk_i,
  input wire logic rst_b_i,
  bspc_byte_if.snk in_if,
  bspc_byte_if.src out_if
);
  logic [7:0] mem_r [2];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] count_r;
  logic push;
  logic pop;

  // Two entries let the engine keep pushing for one cycle after the receiver stalls.
  assign in_if.ready = (count_r != 2'd2);
  assign out_if.valid = (count_r != 2'd0);
  assign out_if.data = mem_r[rd_ptr_r];
  assign push = in_if.valid & in_if.ready;
  assign pop = out_if.valid & out_if.ready;

  // Storage carries no reset; only occupied entries are ever shown.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_if.data;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : bspc_skid_fifo
`default_nettype wire

// >>> verilog/bspc_top.sv
// Behaviour
// - Length byte: upper nibble zero, low count.
// - Command 44h returns length, data, check word.
// - Return zero to eight buffer bytes.
// - Inverted CRC over command, length, data.
// - Command 55h returns status plus inverted CRC.
// - Bit 0 set when first port wrote.
// - Bit 1 set when second port wrote.
// - Bit 2 shows first line level.
// - Bit 3 is second line AND supply.
// - Bit 4 shows charge comparator output.
// - Bit 5 shows grant pin level.
// - Bit 6 set after read, cleared on reload.
// - Bit 7 shows supply-powered versus parasitic.
// - Pins update only when complement check passes.
// - Zero drives pin low, one releases.
// - Pins A,B,C at bits 0-2, reset released.
// - Pin A ignored while port-A buffer signal enabled.
// - Pin B ignored while port-B buffer signal enabled.
// - Pin C ignored while pin C function zero.
// - Non-empty write sets own writer flag, clears other.
// - Empty buffer returns length zero then CRC.
`timescale 1ns/1ps
`default_nettype none
module bspc_top
  import bspc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic txn_start_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic rx_ready_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic buf_byte_we_i,
  input wire logic [2:0] buf_byte_idx_i,
  input wire logic [7:0] buf_byte_i,
  input wire logic buf_commit_i,
  input wire logic buf_commit_port_i,
  input wire logic [3:0] buf_commit_len_i,
  input wire logic first_port_line_i,
  input wire logic second_port_line_i,
  input wire logic logic_supply_i,
  input wire logic charge_comparator_out_i,
  input wire logic grant_pin_level_i,
  input wire logic timer_reload_i,
  input wire logic power_source_flag_i,
  input wire logic port_a_buffer_signal_en_i,
  input wire logic port_b_buffer_signal_en_i,
  input wire logic pin_c_func_sel_i,
  input wire logic [2:0] gpio_pin_i,
  output logic [2:0] gpio_pin_o,
  output logic [2:0] gpio_pin_oe_b_o,
  output logic [7:0] gpio_output_latch_o
);
  // Reply engine states; DONE swallows bytes until the next transaction start.
  typedef enum logic [1:0] {
    BSPC_IDLE,
    BSPC_SEND,
    BSPC_PARAM,
    BSPC_DONE
  } bspc_state_e;

  // One step of the reflected check word, bit by bit from the byte's LSB.
  function automatic logic [15:0] bspc_crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ b[i]) begin
        c = (c >> 1) ^ BSPC_CRC_POLY_REFL;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction : bspc_crc_byte

  // Output byte check: upper nibble is the inverted lower one, with bit 7 high and bit 3 low.
  // The fixed bits are checked too, so a byte with both framing bits flipped cannot slip through.
  function automatic logic bspc_gpio_byte_ok(input logic [7:0] b);
    return (b[7:4] == ~b[3:0]) && !b[3];
  endfunction : bspc_gpio_byte_ok

  // Reply engine bookkeeping.
  bspc_state_e state_r;
  logic [7:0] cmd_r;
  logic [15:0] crc_r;
  logic [3:0] idx_r;
  logic [3:0] last_r;
  logic [3:0] rd_len_r;
  logic [7:0] status_snap_r;
  // Shared buffer and the flags that describe its last writer.
  logic [7:0] buf_mem_r [BSPC_BUF_DEPTH];
  logic [3:0] byte_count_r;
  logic port_a_writer_flag_r;
  logic port_b_writer_flag_r;
  logic timer_restart_r;
  // General pin control.
  logic [7:0] gpio_output_latch_r;
  logic [2:0] gpio_oe_b_r;
  // Combinational helpers.
  logic [7:0] bridge_status;
  logic [7:0] out_byte;
  logic rx_fire;
  logic push_fire;
  logic payload_byte;
  logic send_done;

  // Engine to buffer, and buffer to the byte port.
  bspc_byte_if push_if ();
  bspc_byte_if pop_if ();

  // Output buffer; a stalled receiver holds the engine through push_if.ready.
  bspc_skid_fifo u_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_if(push_if.snk),
    .out_if(pop_if.src)
  );

  assign tx_valid_o = pop_if.valid;
  assign tx_data_o = pop_if.data;
  assign pop_if.ready = tx_ready_i;
  assign push_if.valid = (state_r == BSPC_SEND);
  assign push_if.data = out_byte;

  // Host bytes are refused while a reply is being produced.
  assign rx_ready_o = (state_r != BSPC_SEND);
  assign rx_fire = rx_valid_i & rx_ready_o;
  assign push_fire = push_if.valid & push_if.ready;
  assign payload_byte = (idx_r < (last_r - 4'd1));
  assign send_done = push_fire & (idx_r == last_r);

  // Live status byte, snapshot taken when the command is accepted.
  always_comb begin
    bridge_status = 8'h00;
    bridge_status[BSPC_ST_PORT_A_WRITER] = port_a_writer_flag_r;
    bridge_status[BSPC_ST_PORT_B_WRITER] = port_b_writer_flag_r;
    bridge_status[BSPC_ST_FIRST_LINE] = first_port_line_i;
    bridge_status[BSPC_ST_SECOND_LINE_SUPPLY] = second_port_line_i & logic_supply_i;
    bridge_status[BSPC_ST_CHARGE_CMP] = charge_comparator_out_i;
    bridge_status[BSPC_ST_GRANT] = grant_pin_level_i;
    bridge_status[BSPC_ST_TIMER_RESTART] = timer_restart_r;
    bridge_status[BSPC_ST_POWER_SOURCE] = power_source_flag_i;
  end

  // Reply byte at the current position: payload first, then inverted check word.
  always_comb begin
    out_byte = 8'h00;
    if (idx_r == (last_r - 4'd1)) begin
      out_byte = ~crc_r[7:0];
    end else if (idx_r == last_r) begin
      out_byte = ~crc_r[15:8];
    end else if (cmd_r == BSPC_CMD_READ_STATUS) begin
      out_byte = status_snap_r;
    end else if (idx_r == 4'd0) begin
      out_byte = {4'h0, rd_len_r};
    end else begin
      out_byte = buf_mem_r[3'(idx_r - 4'd1)];
    end
  end

  // Command sequencer; a new transaction start aborts whatever is in flight.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_r <= BSPC_IDLE;
      cmd_r <= 8'h00;
      idx_r <= 4'h0;
      last_r <= 4'h0;
    end else if (txn_start_i) begin
      state_r <= BSPC_IDLE;
    end else begin
      unique case (state_r)
        BSPC_IDLE: begin
          if (rx_fire) begin
            cmd_r <= rx_data_i;
            idx_r <= 4'h0;
            if (rx_data_i == BSPC_CMD_READ_BUF) begin
              state_r <= BSPC_SEND;
              last_r <= byte_count_r + BSPC_CRC_BYTES;
            end else if (rx_data_i == BSPC_CMD_READ_STATUS) begin
              state_r <= BSPC_SEND;
              last_r <= BSPC_CRC_BYTES;
            end else if (rx_data_i == BSPC_CMD_GPIO_WRITE) begin
              state_r <= BSPC_PARAM;
            end else begin
              state_r <= BSPC_DONE;
            end
          end
        end
        BSPC_SEND: begin
          if (push_fire) begin
            idx_r <= idx_r + 4'd1;
          end
          if (send_done) begin
            state_r <= BSPC_DONE;
          end
        end
        BSPC_PARAM: begin
          if (rx_fire) begin
            state_r <= BSPC_DONE;
          end
        end
        // Held here so trailing host bytes cannot start a second command.
        BSPC_DONE: begin
          state_r <= BSPC_DONE;
        end
      endcase
    end
  end

  // Length and status snapshot, so a buffer commit mid-reply cannot change them; data bytes are read live.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rd_len_r <= 4'h0;
      status_snap_r <= 8'h00;
    end else if (state_r == BSPC_IDLE && rx_fire && !txn_start_i) begin
      rd_len_r <= byte_count_r;
      status_snap_r <= bridge_status;
    end
  end

  // Check word covers the command byte and every payload byte sent.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      crc_r <= BSPC_CRC_SEED;
    end else if (state_r == BSPC_IDLE && rx_fire) begin
      crc_r <= bspc_crc_byte(BSPC_CRC_SEED, rx_data_i);
    end else if (state_r == BSPC_SEND && push_fire && payload_byte) begin
      crc_r <= bspc_crc_byte(crc_r, out_byte);
    end
  end

  // Shared buffer contents, filled by the write path outside this block.
  always_ff @(posedge clk_i) begin
    if (buf_byte_we_i) begin
      buf_mem_r[buf_byte_idx_i] <= buf_byte_i;
    end
  end

  // Commit of a buffer write: length above eight leaves everything alone.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      byte_count_r <= 4'h0;
      port_a_writer_flag_r <= 1'b0;
      port_b_writer_flag_r <= 1'b0;
    end else if (buf_commit_i && buf_commit_len_i <= BSPC_BUF_MAX_LEN) begin
      byte_count_r <= buf_commit_len_i;
      if (buf_commit_len_i == 4'h0) begin
        port_a_writer_flag_r <= 1'b0;
        port_b_writer_flag_r <= 1'b0;
      end else begin
        port_a_writer_flag_r <= ~buf_commit_port_i;
        port_b_writer_flag_r <= buf_commit_port_i;
      end
    end
  end

  // Restart flag: set after a status reply wins over a reload in the same cycle.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      timer_restart_r <= 1'b0;
    end else if (send_done && cmd_r == BSPC_CMD_READ_STATUS) begin
      timer_restart_r <= 1'b1;
    end else if (timer_reload_i) begin
      timer_restart_r <= 1'b0;
    end
  end

  // Output byte latched only when its upper nibble complements the lower.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      gpio_output_latch_r <= BSPC_GPIO_LATCH_RST;
    end else if (state_r == BSPC_PARAM && rx_fire && !txn_start_i &&
                 bspc_gpio_byte_ok(rx_data_i)) begin
      gpio_output_latch_r <= rx_data_i;
    end
  end

  // Open-drain drive; a pin owned by its special function is released here.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      gpio_oe_b_r <= 3'b111;
    end else begin
      gpio_oe_b_r[0] <= port_a_buffer_signal_en_i | gpio_output_latch_r[BSPC_GPIO_A_BIT];
      gpio_oe_b_r[1] <= port_b_buffer_signal_en_i | gpio_output_latch_r[BSPC_GPIO_B_BIT];
      gpio_oe_b_r[2] <= ~pin_c_func_sel_i | gpio_output_latch_r[BSPC_GPIO_C_BIT];
    end
  end

  // Pins only ever pull low; their sensed level is not used by these commands.
  assign gpio_pin_o = 3'b000;
  assign gpio_pin_oe_b_o = gpio_oe_b_r;
  assign gpio_output_latch_o = gpio_output_latch_r;

  // Sensed pin levels belong to the pin read command, which is not part of this block.
  logic unused_pins;
  assign unused_pins = ^gpio_pin_i;
endmodule : bspc_top
`default_nettype wire

// >>> verif/bspc_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module bspc_top_monitor (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic txn_start_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_ready_o,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic port_a_buffer_signal_en_i,
  input wire logic port_b_buffer_signal_en_i,
  input wire logic pin_c_func_sel_i,
  input wire logic [2:0] gpio_pin_o,
  input wire logic [2:0] gpio_pin_oe_b_o,
  input wire logic [7:0] gpio_output_latch_o
);
  logic take;
  logic cmd_r;
  logic par_r;
  logic len_r;
  logic [2:0] oe_exp;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // A byte counts as taken only when no new transaction starts in that cycle.
  assign take = rx_valid_i && rx_ready_o && !txn_start_i;
  // A pin owned by its special function stays released whatever the latch says.
  assign oe_exp = {~pin_c_func_sel_i, port_b_buffer_signal_en_i, port_a_buffer_signal_en_i}
    | gpio_output_latch_o[2:0];
  // Marks the byte after a transaction start as the command.
  always_ff @(posedge clk_i) begin
    cmd_r <= rst_b_i && (txn_start_i || (cmd_r && !take));
  end
  // Marks the byte after a pin write command as its parameter.
  always_ff @(posedge clk_i) begin
    par_r <= rst_b_i && !txn_start_i && (take ? cmd_r && rx_data_i == 8'h66 : par_r);
  end
  // Marks that the next reply byte is the length byte of a buffer read.
  always_ff @(posedge clk_i) begin
    len_r <= rst_b_i && ((take && cmd_r && rx_data_i == 8'h44)
      || (len_r && !(tx_valid_o && tx_ready_i)));
  end
  reset_idle_a: assert property (disable iff (1'b0) !rst_b_i |=> gpio_pin_oe_b_o == 3'h7
    && gpio_output_latch_o == 8'h87 && !tx_valid_o) else $error("reset state wrong");
  pin_low_a: assert property (gpio_pin_o == 3'h0)
    else $error("pin level not low");
  latch_chk_a: assert property ($changed(gpio_output_latch_o) |->
    gpio_output_latch_o[7:4] == ~gpio_output_latch_o[3:0] && !gpio_output_latch_o[3])
    else $error("latch took a bad byte");
  latch_load_a: assert property (take && par_r && !rx_data_i[3]
    && rx_data_i[7:4] == ~rx_data_i[3:0] |=> gpio_output_latch_o == $past(rx_data_i))
    else $error("latch missed a good byte");
  oe_follow_a: assert property ($past(rst_b_i) |-> gpio_pin_oe_b_o == $past(oe_exp))
    else $error("pin enable wrong");
  tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("reply byte lost in stall");
  stat_reply_a: assert property (take && cmd_r && rx_data_i == 8'h55 |=> !rx_ready_o ##1 tx_valid_o)
    else $error("status reply late");
  len_byte_a: assert property (tx_valid_o && tx_ready_i && len_r |-> tx_data_o <= 8'h08)
    else $error("length byte out of range");
endmodule : bspc_top_monitor
bind bspc_top bspc_top_monitor u_bspc_top_monitor (.clk_i, .rst_b_i, .txn_start_i, .rx_valid_i,
  .rx_data_i, .rx_ready_o, .tx_valid_o, .tx_data_o, .tx_ready_i, .port_a_buffer_signal_en_i,
  .port_b_buffer_signal_en_i, .pin_c_func_sel_i, .gpio_pin_o, .gpio_pin_oe_b_o,
  .gpio_output_latch_o);
`default_nettype wire

// >>> verif/bspc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module bspc_host_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o
);
  logic [7:0] got_q[$];
  initial tx_ready_o = 1'b0;
  // A slow host takes only every other cycle, so the reply buffer fills and refuses.
  always @(posedge clk_i) begin
    tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
  end
  // Looked at mid-cycle, where valid and data have settled before the taking edge.
  always @(negedge clk_i) begin
    if (tx_valid_i === 1'b1 && tx_ready_o) got_q.push_back(tx_data_i);
  end
endmodule : bspc_host_model
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
  import bspc_pkg::*;
  logic clk_i = 0, rst_b_i = 0, txn_start_i = 0, rx_valid_i = 0, rx_ready_o, tx_valid_o;
  logic tx_ready_i, buf_byte_we_i = 0, buf_commit_i = 0, buf_commit_port_i = 0, slow = 0;
  logic timer_reload_i = 0, fa = 0, fb = 0, trst = 0;
  logic [7:0] rx_data_i = 0, tx_data_o, buf_byte_i = 0, gpio_output_latch_o, lat = 8'h87;
  logic [2:0] buf_byte_idx_i = 0, gpio_pin_o, gpio_pin_oe_b_o, cfg = 0;
  logic [3:0] buf_commit_len_i = 0;
  logic [5:0] lv = 0;
  logic [31:0] seed = 32'h062d;
  logic [7:0] mem [8];
  logic [7:0] exp_q[$];
  int num_errors = 0, total_checks = 0, cyc = 0, byte_count = 0;
  int lens[6] = '{8, 3, 0, 5, 9, 1};
  always #2.5 clk_i = ~clk_i;
  bspc_top u_bspc_top (.clk_i, .rst_b_i, .txn_start_i, .rx_valid_i, .rx_data_i, .rx_ready_o,
    .tx_valid_o, .tx_data_o, .tx_ready_i, .buf_byte_we_i, .buf_byte_idx_i, .buf_byte_i,
    .buf_commit_i, .buf_commit_port_i, .buf_commit_len_i, .first_port_line_i(lv[0]),
    .second_port_line_i(lv[1]), .logic_supply_i(lv[2]), .charge_comparator_out_i(lv[3]),
    .grant_pin_level_i(lv[4]), .power_source_flag_i(lv[5]), .timer_reload_i,
    .port_a_buffer_signal_en_i(cfg[0]), .port_b_buffer_signal_en_i(cfg[1]),
    .pin_c_func_sel_i(cfg[2]), .gpio_pin_i(3'h0), .gpio_pin_o, .gpio_pin_oe_b_o,
    .gpio_output_latch_o);
  bspc_host_model u_bspc_host_model (.clk_i, .slow_i(slow), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ d[i]) ? (c >> 1) ^ BSPC_CRC_POLY_REFL : c >> 1;
    return c;
  endfunction : crc
  // Holds a host byte until the edge that takes it; valid stays up for back-to-back bytes.
  task automatic send(input logic [7:0] b);
    rx_valid_i <= 1'b1;
    rx_data_i <= b;
    @(negedge clk_i);
    while (rx_ready_o !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
  endtask : send
  task automatic start();
    txn_start_i <= 1'b1;
    @(posedge clk_i);
    txn_start_i <= 0;
  endtask : start
  // Appends the inverted check word to the expected payload and compares the whole reply.
  task automatic xfer(input logic [7:0] cmd);
    logic [15:0] c;
    c = crc(BSPC_CRC_SEED, cmd);
    foreach (exp_q[i]) c = crc(c, exp_q[i]);
    exp_q.push_back(~c[7:0]);
    exp_q.push_back(~c[15:8]);
    start();
    send(cmd);
    rx_valid_i <= 1'b0;
    while (u_bspc_host_model.got_q.size() < exp_q.size()) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    `CHK(u_bspc_host_model.got_q.size(), exp_q.size())
    foreach (exp_q[i]) `CHK(u_bspc_host_model.got_q[i], exp_q[i])
    u_bspc_host_model.got_q.delete();
    exp_q.delete();
  endtask : xfer
  // A length above eight must leave buffer and flags as they were.
  task automatic commit(input logic p, input int len);
    for (int i = 0; i < len && len <= 8; i++) begin
      mem[i] = 8'(rnd());
      buf_byte_we_i <= 1'b1;
      buf_byte_idx_i <= 3'(i);
      buf_byte_i <= mem[i];
      @(posedge clk_i);
    end
    buf_byte_we_i <= 1'b0;
    buf_commit_i <= 1'b1;
    buf_commit_port_i <= p;
    buf_commit_len_i <= 4'(len);
    @(posedge clk_i);
    buf_commit_i <= 1'b0;
    if (len <= 8) begin
      byte_count = len;
      fa = len != 0 && !p;
      fb = len != 0 && p;
    end
  endtask : commit
  task automatic st();
    lv <= 6'(rnd());
    @(posedge clk_i);
    exp_q.push_back({lv[5], trst, lv[4], lv[3], lv[1] & lv[2], lv[0], fb, fa});
    xfer(BSPC_CMD_READ_STATUS);
    trst = 1'b1;
    if (seed[3]) begin
      timer_reload_i <= 1'b1;
      @(posedge clk_i);
      timer_reload_i <= 1'b0;
      trst = 1'b0;
    end
  endtask : st
  // Half the output bytes are well formed, the rest random and mostly refused.
  task automatic gpio();
    logic [7:0] p;
    p = 8'(rnd());
    if (p[0]) p = {1'b1, ~p[6:4], 1'b0, p[6:4]};
    cfg <= 3'(rnd());
    start();
    send(BSPC_CMD_GPIO_WRITE);
    send(p);
    rx_valid_i <= 1'b0;
    if (p[7:4] == ~p[3:0] && !p[3]) lat = p;
    repeat (3) @(negedge clk_i);
    `CHK(gpio_output_latch_o, lat)
    `CHK(gpio_pin_oe_b_o, {~cfg[2], cfg[1:0]} | lat[2:0])
    `CHK(gpio_pin_o, 3'h0)
    @(posedge clk_i);
  endtask : gpio
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // The run needs a few hundred cycles; a hang is cut off well beyond that.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // Each buffer length is written from a port that changes every second length, read back, then status twice.
  initial begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(negedge clk_i);
    `CHK(gpio_output_latch_o, 8'h87)
    `CHK(gpio_pin_oe_b_o, 3'h7)
    @(posedge clk_i);
    foreach (lens[k]) begin
      slow <= k[0];
      commit(k[1], lens[k]);
      exp_q.push_back({4'h0, 4'(byte_count)});
      for (int i = 0; i < byte_count; i++) exp_q.push_back(mem[i]);
      xfer(BSPC_CMD_READ_BUF);
      st();
      st();
    end
    for (int k = 0; k < 16; k++) gpio();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
